//--- periodic_wakeup_timer.sv
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module periodic_wakeup_timer
  import wakeup_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_CYCLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // crystal clock pin
  input  wire logic        ext_clk,
  // interrupt request
  output logic             irq,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  wakeup_link_if lnk ();

  // control fields
  logic        flag_r;
  logic        src_r;
  logic        ie_r;
  logic [2:0]  dly_r;
  logic        irq_r;
  logic        restart_r;

  // write channel holding
  logic        aw_full_r;
  logic [31:0] awaddr_r;
  logic        awready_r;
  logic        w_full_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;

  // read channel
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // decoded strobes
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_write;
  logic        wr_hit;
  logic        cfg_wr;
  logic        ack_wr;
  logic        aw_full_nxt;
  logic        w_full_nxt;
  logic        bvalid_nxt;
  logic        rvalid_nxt;
  logic [31:0] rdata_nxt;

  // word-aligned address match, used by both read and write
  function automatic logic addr_hit(input logic [31:0] a);
    return a[31:2] == CTRL_STATUS_OFS[31:2];
  endfunction

  wakeup_tick_gen #(
    .OSC_DIV (OSC_DIV)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ext_clk (ext_clk),
    .lnk     (lnk)
  );

  wakeup_period_counter u_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lnk     (lnk)
  );

  // handshake and commit strobes
  assign aw_hs    = s_axi_awvalid & awready_r;
  assign w_hs     = s_axi_wvalid & wready_r;
  assign ar_hs    = s_axi_arvalid & arready_r;
  assign do_write = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_hit   = do_write & addr_hit(awaddr_r);
  // only the low byte lane holds the register
  assign cfg_wr   = wr_hit & wstrb_r[0];
  assign ack_wr   = cfg_wr & wdata_r[ACK_BIT];

  // next-state of the channel holders; response blocks new addresses
  assign aw_full_nxt = (aw_full_r | aw_hs) & ~do_write;
  assign w_full_nxt  = (w_full_r | w_hs) & ~do_write;
  assign bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready);
  assign rvalid_nxt  = ar_hs | (rvalid_r & ~s_axi_rready);

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awaddr_r  <= 32'h0000_0000;
      awready_r <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      awready_r <= ~aw_full_nxt & ~bvalid_nxt;
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr;
      end
    end
  end

  // write data capture, independent of the address order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      wready_r <= 1'b0;
    end else begin
      w_full_r <= w_full_nxt;
      wready_r <= ~w_full_nxt & ~bvalid_nxt;
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // write response, slverr for an unmapped word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else begin
      bvalid_r <= bvalid_nxt;
      if (do_write) begin
        bresp_r <= addr_hit(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // writable fields; flag is not written here at all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_r <= CTRL_RESET[SRC_BIT];
      ie_r  <= CTRL_RESET[IE_BIT];
      dly_r <= CTRL_RESET[DLY_MSB:DLY_LSB];
    end else if (cfg_wr) begin
      src_r <= wdata_r[SRC_BIT];
      ie_r  <= wdata_r[IE_BIT];
      dly_r <= wdata_r[DLY_MSB:DLY_LSB];
    end
  end

  // any config write restarts the count so a new delay starts clean
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= cfg_wr;
    end
  end

  // timeout flag; an expiry in the acknowledge cycle still sets it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= CTRL_RESET[FLAG_BIT];
    end else if (lnk.expire) begin
      flag_r <= 1'b1;
    end else if (ack_wr) begin
      flag_r <= 1'b0;
    end
  end

  // registered request, follows flag and enable one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_r & ie_r;
    end
  end

  // link drive toward the timer core
  assign lnk.src     = src_r;
  assign lnk.restart = restart_r;
  assign lnk.period  = period_of(src_r, dly_r);

  // read mux; ack and bit 3 and upper bits read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (addr_hit(s_axi_araddr)) begin
      rdata_nxt[FLAG_BIT]        = flag_r;
      rdata_nxt[SRC_BIT]         = src_r;
      rdata_nxt[IE_BIT]          = ie_r;
      rdata_nxt[DLY_MSB:DLY_LSB] = dly_r;
    end
  end

  // read channel, answer the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= rdata_nxt;
        rresp_r <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // port drive, all from flops
  assign irq           = irq_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // checks on flag, fields and bus timing
  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn)
    lnk.expire |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("expiry did not set flag");

  property p_flag_quiet;
    @(posedge aclk) disable iff (!aresetn)
    (!flag_r && !lnk.expire) |=> !flag_r;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("flag set without expiry");

  property p_ack_clear;
    @(posedge aclk) disable iff (!aresetn)
    (ack_wr && !lnk.expire) |=> !flag_r;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear flag");

  property p_zero_ack;
    @(posedge aclk) disable iff (!aresetn)
    (cfg_wr && !wdata_r[ACK_BIT] && flag_r) |=> flag_r;
  endproperty
  a_zero_ack: assert property (p_zero_ack) else $error("zero ack cleared flag");

  property p_read_zeros;
    @(posedge aclk) disable iff (!aresetn)
    rvalid_r |-> (rdata_r[ACK_BIT] == 1'b0 && rdata_r[3] == 1'b0 && rdata_r[31:8] == 24'h000000);
  endproperty
  a_read_zeros: assert property (p_read_zeros) else $error("unused bits read nonzero");

  property p_irq_follow;
    @(posedge aclk) disable iff (!aresetn)
    ##1 irq_r == ($past(flag_r) & $past(ie_r));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq not flag and enable");

  property p_fields_write;
    @(posedge aclk) disable iff (!aresetn)
    cfg_wr |=> (src_r == $past(wdata_r[SRC_BIT]) && ie_r == $past(wdata_r[IE_BIT])
                && dly_r == $past(wdata_r[DLY_MSB:DLY_LSB]));
  endproperty
  a_fields_write: assert property (p_fields_write) else $error("field write lost");

  property p_int_period;
    @(posedge aclk) disable iff (!aresetn)
    (!src_r && dly_r == 3'h1) |-> lnk.period == 16'h0008;
  endproperty
  a_int_period: assert property (p_int_period) else $error("internal 8 ms period wrong");

  property p_ext_period;
    @(posedge aclk) disable iff (!aresetn)
    (src_r && dly_r == 3'h7) |-> lnk.period == 16'h8000;
  endproperty
  a_ext_period: assert property (p_ext_period) else $error("external divide wrong");

  property p_reset_zero;
    @(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> (!flag_r && !src_r && !ie_r && dly_r == 3'h0 && !irq_r);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("fields not zero after reset");

  // write answer one cycle after both halves are held
  property p_bresp_time;
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid_r;
  endproperty
  a_bresp_time: assert property (p_bresp_time) else $error("write answer late");

  property p_read_time;
    @(posedge aclk) disable iff (!aresetn)
    ar_hs |=> rvalid_r;
  endproperty
  a_read_time: assert property (p_read_time) else $error("read answer late");

  // main scenarios
  c_expire: cover property (@(posedge aclk) disable iff (!aresetn) lnk.expire);
  c_ack:    cover property (@(posedge aclk) disable iff (!aresetn) flag_r ##1 ack_wr);
  c_irq:    cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_r));
  c_ext:    cover property (@(posedge aclk) disable iff (!aresetn) src_r && lnk.expire);
endmodule
`default_nettype wire

//--- periodic_wakeup_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module periodic_wakeup_timer_test;
  import wakeup_pkg::*;
  // short oscillator divide keeps the slowest internal period near 4k cycles
  localparam int          DIV  = 4;
  localparam logic [31:0] OK32 = {30'h0, RESP_OKAY};
  localparam logic [31:0] ER32 = {30'h0, RESP_SLVERR};
  localparam logic [31:0] OFS  = CTRL_STATUS_OFS;

  logic        aclk, aresetn, ext_clk, ext_run, irq;
  logic [1:0]  ext_cnt, bresp, rresp;
  logic [31:0] awaddr, wdata, araddr, rdata, d, r, hi;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          num_errors, total_checks;
  int          it[7] = '{8, 32, 64, 128, 256, 512, 1024};
  int          et[4] = '{256, 1024, 2048, 4096};

  periodic_wakeup_timer #(.OSC_DIV(DIV)) uut (
    .aclk(aclk), .aresetn(aresetn), .ext_clk(ext_clk), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  // bus clock, 100 ns
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // crystal stand-in, four bus cycles a period; parked low while not running
  always @(posedge aclk) begin
    if (ext_run) begin
      ext_cnt <= ext_cnt + 2'h1;
      ext_clk <= ext_cnt[1];
    end else begin
      ext_cnt <= 2'h0;
      ext_clk <= 1'b0;
    end
  end

  task end_of_test;
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task timeout;
    num_errors++;
    end_of_test();
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask

  // address and data offered together, bready held until the answer
  task wr(input logic [31:0] a, input logic [31:0] v, output logic [31:0] resp);
    logic done;
    done = 1'b0;
    resp = 32'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = {30'h0, bresp};
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) timeout();
  endtask

  task rd(input logic [31:0] a, output logic [31:0] v, output logic [31:0] resp);
    logic done;
    done = 1'b0;
    v = 32'h0;
    resp = 32'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        resp = {30'h0, rresp};
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) timeout();
  endtask

  // counts cycles with the request not low
  task idle(input int n, output logic [31:0] h);
    h = 32'h0;
    repeat (n) begin
      @(posedge aclk);
      if (irq !== 1'b0) h = h + 32'h1;
    end
  endtask

  // ack plus new setting restarts the count; request must rise near exp
  task timed(input logic [7:0] cfg, input int exp, input int lo);
    int n;
    wr(OFS, {24'h0, cfg | 8'h40}, r);
    // registered request needs two edges to fall after the ack
    repeat (2) @(posedge aclk);
    n = 2;
    while (irq !== 1'b1 && n < exp + 40) begin
      @(posedge aclk);
      n++;
    end
    check({31'h0, n >= exp - lo && n <= exp + 16}, 32'h1);
    rd(OFS, d, r);
    check(d, {24'h0, cfg | 8'h80});
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge aclk);
    timeout();
  end

  initial begin
    aresetn = 1'b0;
    ext_run = 1'b0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    num_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS, d, r);
    check(d, 32'h0000_0000);
    check(r, OK32);
    // all ones: flag, ack, bit 3 and upper bits come back zero
    wr(OFS, 32'hFFFF_FFFF, r);
    check(r, OK32);
    rd(OFS, d, r);
    check(d, 32'h0000_0037);
    // byte lane 0 not strobed, no change
    wstrb <= 4'hE;
    wr(OFS, 32'h0, r);
    wstrb <= 4'hF;
    rd(OFS, d, r);
    check(d, 32'h0000_0037);
    // unmapped word refused, register untouched
    wr(32'h0000_0004, 32'h0, r);
    check(r, ER32);
    rd(32'h0000_0004, d, r);
    check(d, 32'h0);
    check(r, ER32);
    rd(OFS, d, r);
    check(d, 32'h0000_0037);
    // enable off: flag sets but request stays low
    wr(OFS, 32'h0000_0041, r);
    idle(80, hi);
    check(hi, 32'h0);
    rd(OFS, d, r);
    check(d, 32'h0000_0081);
    // enabling with the flag pending raises the request
    wr(OFS, 32'h0000_0011, r);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    rd(OFS, d, r);
    check(d, 32'h0000_0091);
    wr(OFS, 32'h0000_0001, r);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    // stop first so no late expiry can land on the ack
    wr(OFS, 32'h0000_0000, r);
    // ack with code zero: flag clears and the timer stays stopped
    wr(OFS, 32'h0000_0050, r);
    idle(300, hi);
    check(hi, 32'h0);
    rd(OFS, d, r);
    check(d, 32'h0000_0010);
    ext_run <= 1'b1;
    wr(OFS, 32'h0000_0070, r);
    idle(1500, hi);
    check(hi, 32'h0);
    // silent crystal; long enough for 256 oscillator ticks to show
    ext_run <= 1'b0;
    wr(OFS, 32'h0000_0071, r);
    idle(1300, hi);
    check(hi, 32'h0);
    for (int i = 0; i < 7; i++) timed(8'h11 + 8'(i), it[i] * DIV, DIV + 4);
    ext_run <= 1'b1;
    for (int i = 0; i < 4; i++) timed(8'h31 + 8'(i), et[i] * 4, 6);
    // second reset in mid-run clears every field
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS, d, r);
    check(d, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire

//--- wakeup_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wakeup_link_if;
  logic        src;      // 0 internal, 1 external
  logic        tick;     // one tick of the selected source
  logic        restart;  // config changed, start count over
  logic [15:0] period;   // ticks per timeout, zero stops
  logic        expire;   // one-cycle timeout pulse
  modport gen (input src, output tick);
  modport cnt (input tick, input restart, input period, output expire);
  modport ctl (output src, output restart, output period, input expire);
endinterface
`default_nettype wire

//--- wakeup_period_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wakeup_period_counter
  import wakeup_pkg::*;
(
  // clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // link to control
  wakeup_link_if.cnt lnk
);
  logic [PERIOD_W-1:0] cnt_r;
  logic                expire_r;

  // tick counter; a period of zero holds it parked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= 16'h0000;
      expire_r <= 1'b0;
    end else if (lnk.restart || lnk.period == 16'h0000) begin
      cnt_r    <= 16'h0000;
      expire_r <= 1'b0;
    end else if (lnk.tick && cnt_r == lnk.period - 16'h0001) begin
      cnt_r    <= 16'h0000;
      expire_r <= 1'b1;
    end else begin
      cnt_r    <= lnk.tick ? cnt_r + 16'h0001 : cnt_r;
      expire_r <= 1'b0;
    end
  end

  assign lnk.expire = expire_r;

  property p_stop_no_expire;
    @(posedge aclk) disable iff (!aresetn)
    (lnk.period == 16'h0000) |=> !expire_r;
  endproperty
  a_stop_no_expire: assert property (p_stop_no_expire) else $error("expiry while stopped");

  property p_expire_wraps;
    @(posedge aclk) disable iff (!aresetn)
    expire_r |-> (cnt_r == 16'h0000);
  endproperty
  a_expire_wraps: assert property (p_expire_wraps) else $error("count not wrapped on expiry");
endmodule
`default_nettype wire

//--- wakeup_pkg.sv
`default_nettype none
package wakeup_pkg;
  // register map, one aligned word
  localparam logic [31:0] CTRL_STATUS_OFS = 32'h0000_0000;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam int          FLAG_BIT        = 7;
  localparam int          ACK_BIT         = 6;
  localparam int          SRC_BIT         = 5;
  localparam int          IE_BIT          = 4;
  localparam int          DLY_MSB         = 2;
  localparam int          DLY_LSB         = 0;
  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  // timing: bus clock and internal oscillator rate
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          OSC_FREQ_HZ     = 1000;
  localparam int          OSC_DIV_CYCLES  = 1000000000 / (OSC_FREQ_HZ * CLK_PERIOD_NS);
  localparam int          PERIOD_W        = 16;

  // ticks of the selected source per timeout; zero means stopped
  function automatic logic [PERIOD_W-1:0] period_of(input logic src, input logic [2:0] dly);
    logic [PERIOD_W-1:0] p;
    p = 16'h0000;
    unique case (dly)
      3'h0: p = 16'h0000;
      3'h1: p = src ? 16'h0100 : 16'h0008;
      3'h2: p = src ? 16'h0400 : 16'h0020;
      3'h3: p = src ? 16'h0800 : 16'h0040;
      3'h4: p = src ? 16'h1000 : 16'h0080;
      3'h5: p = src ? 16'h2000 : 16'h0100;
      3'h6: p = src ? 16'h4000 : 16'h0200;
      3'h7: p = src ? 16'h8000 : 16'h0400;
    endcase
    return p;
  endfunction
endpackage
`default_nettype wire

//--- wakeup_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module wakeup_tick_gen
  import wakeup_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_CYCLES
) (
  // clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // crystal clock pin
  input  wire logic  ext_clk,
  // link to counter
  wakeup_link_if.gen lnk
);
  logic [15:0] osc_cnt_r;
  logic        osc_tick_r;
  logic        sync1_r;
  logic        sync2_r;
  logic        sync3_r;

  // free-running 1 kHz divider, never reset by config so it stays independent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_r  <= 16'h0000;
      osc_tick_r <= 1'b0;
    end else if (osc_cnt_r == 16'(OSC_DIV - 1)) begin
      osc_cnt_r  <= 16'h0000;
      osc_tick_r <= 1'b1;
    end else begin
      osc_cnt_r  <= osc_cnt_r + 16'h0001;
      osc_tick_r <= 1'b0;
    end
  end

  // crystal pin synchroniser; edges need the pin below half the bus rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= ext_clk;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // source select: rising crystal edge or oscillator tick
  assign lnk.tick = lnk.src ? (sync2_r & ~sync3_r) : osc_tick_r;
endmodule
`default_nettype wire
